// *** eir_pkg.sv ***
// Constants, register map and types of the external request block.
// Assumes a 32-bit classic Wishbone slave port and a single 125 MHz clock.
// Notes on behaviour
// [RULE_01] Five request inputs: the CAN receive line and four external request pins.
// [RULE_02] Each input has its own detection field in the detection configuration register.
// [RULE_03] High, low, rising or falling detection; transfer service uses levels only.
// [RULE_04] A request reaches the CPU only while its enable bit is set.
// [RULE_05] Each detected condition is latched in its own cause flag for software.
// [RULE_06] With service select clear an enabled request branches straight to the routine.
// [RULE_07] With service select set each request does one transfer, interrupting after the count.
// [RULE_08] Requests appear on three interrupt vectors: 15, 24 and 27.
// [RULE_09] The CAN receive line feeds the request logic as a wake-up source.
// [RULE_10] A cause flag stays until cleared; clearing withdraws it unless the condition remains.
package eir_pkg;
  localparam int             EIR_NIN        = 5;
  localparam int             EIR_NVEC       = 3;
  localparam int             EIR_AW         = 8;
  localparam int             EIR_CNT_W      = 8;
  localparam int             EIR_CNT_LSB    = 8;
  localparam logic [7:0]     EIR_ADR_ENABLE = 8'h00;
  localparam logic [7:0]     EIR_ADR_CAUSE  = 8'h04;
  localparam logic [7:0]     EIR_ADR_DETECT = 8'h08;
  localparam logic [7:0]     EIR_ADR_ICTRL  = 8'h0c;
  localparam logic [7:0]     EIR_ADR_STATUS = 8'h10;
  localparam logic [4:0]     EIR_RST_ENABLE = 5'h00;
  localparam logic [9:0]     EIR_RST_DETECT = 10'h000;
  localparam logic [2:0]     EIR_RST_SEL    = 3'h0;
  localparam logic [7:0]     EIR_RST_CNT    = 8'h00;
  // Input 0 is the CAN receive line, inputs 1 to 4 are the external request pins.
  localparam logic [2:0][4:0] EIR_VEC_MASK  = {5'h18, 5'h06, 5'h01};
  localparam logic [2:0][7:0] EIR_VEC_NUM   = {8'h1b, 8'h18, 8'h0f};
  typedef enum logic [1:0] {
    EIR_DET_LOW,
    EIR_DET_HIGH,
    EIR_DET_RISE,
    EIR_DET_FALL
  } eir_det_t;
endpackage

// *** eir_ctrl.sv ***
// External request and wake-up block: detection, cause flags, enables and transfer counting.
// Assumes a classic Wishbone master on clk_i and an automatic transfer engine that pulses
// xfer_done_i once per finished transfer, on the same clock.
module eir_ctrl
(
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        can_rx_i,
  input  wire logic [3:0]                  ext_request_pins_i,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [eir_pkg::EIR_AW-1:0]  wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic      [31:0]                 wb_dat_o,
  output logic                             wb_ack_o,
  output logic      [eir_pkg::EIR_NVEC-1:0] irq_o,
  output logic      [eir_pkg::EIR_NVEC-1:0] xfer_req_o,
  input  wire logic [eir_pkg::EIR_NVEC-1:0] xfer_done_i
);
  import eir_pkg::*;

  logic [EIR_NIN-1:0]      pin_meta_ff;
  logic [EIR_NIN-1:0]      pin_sync_ff;
  logic [EIR_NIN-1:0]      pin_prev_ff;
  logic [EIR_NIN-1:0]      request_enable_reg_ff;
  logic [EIR_NIN-1:0]      request_cause_reg_ff;
  logic [2*EIR_NIN-1:0]    detect_condition_cfg_ff;
  logic [EIR_NVEC-1:0]     service_select_bit_ff;
  logic [EIR_CNT_W-1:0]    cnt_ff [EIR_NVEC];
  logic                    ack_ff;
  logic [31:0]             rdat_ff;

  wire  [EIR_NIN-1:0]      pins_raw = {ext_request_pins_i, can_rx_i}; // [RULE_01] [RULE_09]
  wire                     bus_req  = wb_cyc_i & wb_stb_i;
  wire                     bus_wr   = bus_req & wb_we_i & ack_ff;
  wire  [31:0]             wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire                     wr_en    = bus_wr & (wb_adr_i == EIR_ADR_ENABLE);
  wire                     wr_cause = bus_wr & (wb_adr_i == EIR_ADR_CAUSE);
  wire                     wr_det   = bus_wr & (wb_adr_i == EIR_ADR_DETECT);
  wire                     wr_ictl  = bus_wr & (wb_adr_i == EIR_ADR_ICTRL);
  wire  [31:0]             wval     = wb_dat_i & wmask;

  // An input served by the transfer engine only accepts level detection.
  function automatic logic detect(input logic [1:0] cfg, input logic cur, input logic prev,
                                  input logic lvl_only);
    logic hit;
    hit = 1'b0;
    unique case (eir_det_t'(lvl_only ? {1'b0, cfg[0]} : cfg))
      EIR_DET_LOW:  hit = ~cur;
      EIR_DET_HIGH: hit = cur;
      EIR_DET_RISE: hit = cur & ~prev;
      EIR_DET_FALL: hit = ~cur & prev;
    endcase
    return hit;
  endfunction

  // Which vectors an input belongs to; transfer selection and hardware clear both need it.
  function automatic logic [EIR_NVEC-1:0] vec_member(input int idx);
    logic [EIR_NVEC-1:0] m;
    m = '0;
    for (int v = 0; v < EIR_NVEC; v++)
      m[v] = EIR_VEC_MASK[v][idx];
    return m;
  endfunction

  logic [EIR_NIN-1:0]  det_hit;
  logic [EIR_NIN-1:0]  in_xfer;
  logic [EIR_NIN-1:0]  hw_clr;
  logic [EIR_NVEC-1:0] grp_pend;
  logic [EIR_NVEC-1:0] cnt_zero;

  genvar gi;
  generate
    for (gi = 0; gi < EIR_NIN; gi++)
    begin : g_in
      assign in_xfer[gi] = |(service_select_bit_ff & vec_member(gi));
      assign hw_clr[gi]  = |(xfer_done_i & service_select_bit_ff & vec_member(gi));
      assign det_hit[gi] = detect(detect_condition_cfg_ff[2*gi +: 2], pin_sync_ff[gi], // [RULE_02] [RULE_03]
                                  pin_prev_ff[gi], in_xfer[gi]);
    end
    for (gi = 0; gi < EIR_NVEC; gi++)
    begin : g_vec
      assign grp_pend[gi]   = |(request_cause_reg_ff & request_enable_reg_ff & EIR_VEC_MASK[gi]); // [RULE_04] [RULE_08]
      assign cnt_zero[gi]   = cnt_ff[gi] == '0;
      // Direct mode branches at once; transfer mode interrupts only when the count is used up.
      assign irq_o[gi]      = grp_pend[gi] & (~service_select_bit_ff[gi] | cnt_zero[gi]); // [RULE_06] [RULE_07]
      assign xfer_req_o[gi] = grp_pend[gi] & service_select_bit_ff[gi] & ~cnt_zero[gi]; // [RULE_07]
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          cnt_ff[gi] <= EIR_RST_CNT;
        else if (wr_ictl && wb_sel_i[gi+1])
          cnt_ff[gi] <= wb_dat_i[EIR_CNT_LSB + EIR_CNT_W*gi +: EIR_CNT_W];
        else if (xfer_done_i[gi] && service_select_bit_ff[gi] && !cnt_zero[gi])
          cnt_ff[gi] <= cnt_ff[gi] - 8'h01; // [RULE_07]
      end
    end
  endgenerate

  // Set wins over clear, so a condition still present keeps the flag up.
  wire [EIR_NIN-1:0] cause_clr = (wr_cause ? wval[EIR_NIN-1:0] : '0) | hw_clr;
  wire [EIR_NIN-1:0] nxt_cause = (request_cause_reg_ff & ~cause_clr) | det_hit; // [RULE_05] [RULE_10]

  always_ff @(posedge clk_i)
  begin
    // No reset here: the chain tracks the idle pins during reset, so no false edge follows it.
    pin_meta_ff <= pins_raw;
    pin_sync_ff <= pin_meta_ff;
    pin_prev_ff <= pin_sync_ff;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      request_enable_reg_ff   <= EIR_RST_ENABLE;
      request_cause_reg_ff    <= '0;
      detect_condition_cfg_ff <= EIR_RST_DETECT;
      service_select_bit_ff   <= EIR_RST_SEL;
    end
    else
    begin
      request_cause_reg_ff <= nxt_cause;
      if (wr_en)
        request_enable_reg_ff <= (request_enable_reg_ff & ~wmask[EIR_NIN-1:0]) | wval[EIR_NIN-1:0];
      if (wr_det)
        detect_condition_cfg_ff <= (detect_condition_cfg_ff & ~wmask[9:0]) | wval[9:0];
      if (wr_ictl && wb_sel_i[0])
        service_select_bit_ff <= wb_dat_i[EIR_NVEC-1:0];
    end
  end

  // Read data is captured one cycle before ack, so it stands with ack.
  wire [31:0] rd_mux =
    (wb_adr_i == EIR_ADR_ENABLE) ? {27'h0, request_enable_reg_ff} :
    (wb_adr_i == EIR_ADR_CAUSE)  ? {27'h0, request_cause_reg_ff} :
    (wb_adr_i == EIR_ADR_DETECT) ? {22'h0, detect_condition_cfg_ff} :
    (wb_adr_i == EIR_ADR_ICTRL)  ? {cnt_ff[2], cnt_ff[1], cnt_ff[0], 5'h00, service_select_bit_ff} :
    (wb_adr_i == EIR_ADR_STATUS) ? {21'h0, irq_o, 3'h0, pin_sync_ff} : 32'h0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0;
    end
    else
    begin
      ack_ff  <= bus_req & ~ack_ff;
      rdat_ff <= rd_mux;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_single:    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_can_wakeup:    assert property (!can_rx_i [*3] ##0 detect_condition_cfg_ff[1:0] == 2'b00 // [RULE_09]
                                    |=> request_cause_reg_ff[0])
    else $error("CAN receive low did not raise the wake-up flag");
  a_pin_level:     assert property (ext_request_pins_i[0] [*3] ##0 detect_condition_cfg_ff[3:2] == 2'b01 // [RULE_01]
                                    |=> request_cause_reg_ff[1])
    else $error("high level on pin did not set its flag");
  a_rise_detect:   assert property (pin_sync_ff[2] && !pin_prev_ff[2] && detect_condition_cfg_ff[5:4] == 2'b10 // [RULE_03]
                                    && !in_xfer[2] |=> request_cause_reg_ff[2])
    else $error("rising edge missed");
  a_cause_holds:   assert property (request_cause_reg_ff[3] && !wr_cause && !hw_clr[3] // [RULE_05]
                                    |=> request_cause_reg_ff[3])
    else $error("cause flag dropped without a clear");
  a_clear_kept:    assert property (wr_cause && wval[1] && det_hit[1] |=> request_cause_reg_ff[1]) // [RULE_10]
    else $error("clear beat a present condition");
  a_enable_gate:   assert property (irq_o[1] || xfer_req_o[1] |-> |(request_enable_reg_ff & 5'h06)) // [RULE_04]
    else $error("request forwarded while disabled");
  a_direct_irq:    assert property (!service_select_bit_ff[0] && request_cause_reg_ff[0] // [RULE_06]
                                    && request_enable_reg_ff[0] |-> irq_o[0] && !xfer_req_o[0])
    else $error("direct mode did not branch");
  a_count_step:    assert property (xfer_done_i[2] && service_select_bit_ff[2] && !cnt_zero[2] // [RULE_07]
                                    && !(wr_ictl && wb_sel_i[3]) |=> cnt_ff[2] == $past(cnt_ff[2]) - 8'h01)
    else $error("transfer count not stepped");
  a_xfer_first:    assert property (service_select_bit_ff[1] && !cnt_zero[1] |-> !irq_o[1]) // [RULE_07]
    else $error("interrupt before transfers were done");

  // Bus answers: one ack per request, with the register value of the cycle before ack.
  a_ack_follows:   assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged in the next cycle");

  a_ack_idle:      assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without a request");

  a_read_unmapped: assert property (bus_req && !wb_ack_o && !wb_we_i && wb_adr_i == 8'h14 |=> wb_dat_o == 32'h0)
    else $error("unmapped read returned data");

  a_read_enable:   assert property (bus_req && !wb_ack_o && wb_adr_i == EIR_ADR_ENABLE // [RULE_04]
                                    |=> wb_dat_o == {27'h0, $past(request_enable_reg_ff)})
    else $error("enable register read back wrong");

  a_read_cause:    assert property (bus_req && !wb_ack_o && wb_adr_i == EIR_ADR_CAUSE // [RULE_05]
                                    |=> wb_dat_o == {27'h0, $past(request_cause_reg_ff)})
    else $error("cause register read back wrong");

  // Register writes land at the edge where ack is high and at no other.
  a_enable_write:  assert property (wr_en && wb_sel_i[0] |=> request_enable_reg_ff == $past(wb_dat_i[4:0])) // [RULE_04]
    else $error("enable write lost");

  a_enable_kept:   assert property (!wr_en |=> $stable(request_enable_reg_ff)) // [RULE_04]
    else $error("enable register changed without a write");

  a_detect_write:  assert property (wr_det && wb_sel_i[1:0] == 2'b11 // [RULE_02]
                                    |=> detect_condition_cfg_ff == $past(wb_dat_i[9:0]))
    else $error("detection write lost");

  a_detect_kept:   assert property (!wr_det |=> $stable(detect_condition_cfg_ff)) // [RULE_02]
    else $error("detection fields changed without a write");

  a_select_write:  assert property (wr_ictl && wb_sel_i[0] // [RULE_06]
                                    |=> service_select_bit_ff == $past(wb_dat_i[2:0]))
    else $error("service select write lost");

  a_select_kept:   assert property (!(wr_ictl && wb_sel_i[0]) |=> $stable(service_select_bit_ff)) // [RULE_06]
    else $error("service select changed without a write");

  a_count_load:    assert property (wr_ictl && wb_sel_i[1] |=> cnt_ff[0] == $past(wb_dat_i[15:8])) // [RULE_07]
    else $error("transfer count write lost");

  // Detection in low, high and falling modes and under transfer service, three edges after the pin moves.
  a_pin_low:       assert property (!ext_request_pins_i[3] [*3] ##0 detect_condition_cfg_ff[9:8] == 2'b00 // [RULE_01]
                                    |=> request_cause_reg_ff[4])
    else $error("low level on pin did not set its flag");

  a_pin_high:      assert property (ext_request_pins_i[2] [*3] ##0 detect_condition_cfg_ff[7:6] == 2'b01 // [RULE_03]
                                    |=> request_cause_reg_ff[3])
    else $error("high level on pin did not set its flag");

  a_fall_detect:   assert property (!pin_sync_ff[3] && pin_prev_ff[3] && detect_condition_cfg_ff[7:6] == 2'b11 // [RULE_03]
                                    && !in_xfer[3] |=> request_cause_reg_ff[3])
    else $error("falling edge missed");

  a_xfer_level:    assert property (in_xfer[0] && pin_sync_ff[0] && detect_condition_cfg_ff[0] // [RULE_03]
                                    |=> request_cause_reg_ff[0])
    else $error("level detection under transfer service missed");

  a_no_false_hit:  assert property (!det_hit[2] && !request_cause_reg_ff[2] |=> !request_cause_reg_ff[2]) // [RULE_05]
    else $error("flag set without a detection");

  a_clear_works:   assert property (wr_cause && wval[2] && !det_hit[2] |=> !request_cause_reg_ff[2]) // [RULE_10]
    else $error("software clear did not drop the flag");

  a_hw_clear:      assert property (hw_clr[0] && !det_hit[0] |=> !request_cause_reg_ff[0]) // [RULE_07]
    else $error("finished transfer did not drop the flag");

  // Forwarding to the three vectors.
  a_irq_flag0:     assert property (irq_o[0] |-> request_cause_reg_ff[0] && request_enable_reg_ff[0]) // [RULE_08]
    else $error("vector 0 raised without an enabled flag");

  a_irq_flag1:     assert property (irq_o[1] |-> |(request_cause_reg_ff & request_enable_reg_ff & 5'h06)) // [RULE_08]
    else $error("vector 1 raised without an enabled flag");

  a_irq_flag2:     assert property (irq_o[2] |-> |(request_cause_reg_ff & request_enable_reg_ff & 5'h18)) // [RULE_08]
    else $error("vector 2 raised without an enabled flag");

  a_xfer_excl0:    assert property (!(irq_o[0] && xfer_req_o[0])) // [RULE_07]
    else $error("vector 0 asks for a transfer and an interrupt at once");

  a_xfer_excl1:    assert property (!(irq_o[1] && xfer_req_o[1])) // [RULE_07]
    else $error("vector 1 asks for a transfer and an interrupt at once");

  a_xfer_excl2:    assert property (!(irq_o[2] && xfer_req_o[2])) // [RULE_07]
    else $error("vector 2 asks for a transfer and an interrupt at once");

  a_xfer_sel1:     assert property (xfer_req_o[1] |-> service_select_bit_ff[1] && !cnt_zero[1]) // [RULE_07]
    else $error("vector 1 transfer without service select");

  a_xfer_sel2:     assert property (xfer_req_o[2] |-> service_select_bit_ff[2] && !cnt_zero[2]) // [RULE_07]
    else $error("vector 2 transfer without service select");

  a_direct_vec1:   assert property (!service_select_bit_ff[1] // [RULE_06]
                                    && |(request_cause_reg_ff & request_enable_reg_ff & 5'h06) |-> irq_o[1])
    else $error("vector 1 direct mode did not branch");

  a_direct_vec2:   assert property (!service_select_bit_ff[2] // [RULE_06]
                                    && |(request_cause_reg_ff & request_enable_reg_ff & 5'h18) |-> irq_o[2])
    else $error("vector 2 direct mode did not branch");

  a_xfer_start:    assert property (service_select_bit_ff[0] && !cnt_zero[0] && request_cause_reg_ff[0] // [RULE_07]
                                    && request_enable_reg_ff[0] |-> xfer_req_o[0])
    else $error("transfer not requested");

  a_irq_after_cnt: assert property (service_select_bit_ff[0] && cnt_zero[0] && grp_pend[0] |-> irq_o[0]) // [RULE_07]
    else $error("no interrupt after the last transfer");

  a_count_hold:    assert property (!xfer_done_i[0] && !(wr_ictl && wb_sel_i[1]) |=> $stable(cnt_ff[0])) // [RULE_07]
    else $error("transfer count moved without a transfer");

  a_count_floor:   assert property (cnt_zero[1] && !(wr_ictl && wb_sel_i[2]) |=> cnt_zero[1]) // [RULE_07]
    else $error("transfer count wrapped below zero");

  a_can_vector:    assert property (request_cause_reg_ff[0] && request_enable_reg_ff[0] |-> grp_pend[0]) // [RULE_09]
    else $error("wake-up flag not routed to its vector");

  c_direct:  cover property (irq_o[0] && !service_select_bit_ff[0]);
  c_xfer:    cover property (xfer_req_o[0] ##[1:20] irq_o[0]);
  c_rise:    cover property (pin_sync_ff[2] && !pin_prev_ff[2] && detect_condition_cfg_ff[5:4] == 2'b10);
  c_clr_set: cover property (wr_cause && wval[1] && det_hit[1]);
  c_bus_rd:  cover property (wb_ack_o && !wb_we_i && wb_adr_i == EIR_ADR_CAUSE);
endmodule

// *** eir_xfer_model.sv ***
// Model of the automatic transfer engine beside the external request block.
// Assumes one clock shared with the block and a synchronous active-high reset.
module eir_xfer_model
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] delay_i,
  input  wire logic [2:0] xfer_req_i,
  output logic      [2:0] xfer_done_o
);
  logic [3:0] wait_ff [3];
  always_ff @(posedge clk_i)
  begin
    for (int v = 0; v < 3; v++)
    begin
      xfer_done_o[v] <= 1'b0;
      // One transfer per pending request, after a delay that the bench picks.
      if (rst_i || !xfer_req_i[v] || xfer_done_o[v])
        wait_ff[v] <= 4'h0;
      else if (wait_ff[v] == delay_i)
        xfer_done_o[v] <= 1'b1;
      else
        wait_ff[v] <= wait_ff[v] + 4'h1;
    end
  end
endmodule

// *** eir_ctrl_test.sv ***
// Self-checking bench of the external request block.
// Assumes eir_pkg, eir_ctrl and the transfer engine model are compiled first.
module eir_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  import eir_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        can_rx_i = 1'b1;
  logic [3:0]  ext_request_pins_i = 4'hf;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [2:0]  irq_o;
  logic [2:0]  xfer_req_o;
  logic [2:0]  xfer_done_i;
  logic [3:0]  delay = 4'h0;
  logic [31:0] exp_q[$];
  int          n_errors = 0;
  int          check_count = 0;
  initial forever #4 clk_i = ~clk_i;
  eir_ctrl eir_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .can_rx_i(can_rx_i), .ext_request_pins_i(ext_request_pins_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .xfer_req_o(xfer_req_o),
    .xfer_done_i(xfer_done_i));
  eir_xfer_model eir_xfer_model_i (.clk_i(clk_i), .rst_i(rst_i), .delay_i(delay), .xfer_req_i(xfer_req_o),
    .xfer_done_o(xfer_done_i));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expd);
    check_count++;
    if (seen !== expd)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, expd, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic hang(input string what);
    check(what, 32'h0, 32'h1);
    end_of_test();
  endtask
  // Reads note their expected word; the monitor below compares it when ack arrives.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [31:0] expd);
    int i;
    @(posedge clk_i);
    if (!we)
      exp_q.push_back(expd);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++)
      @(posedge clk_i);
    if (i == 20)
      hang("ack wait");
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic set_in(input logic [4:0] mask, input logic lvl);
    @(posedge clk_i);
    {ext_request_pins_i, can_rx_i} <= (mask & {5{lvl}}) | ~mask;
  endtask
  always @(posedge clk_i)
    if (wb_ack_o === 1'b1 && !wb_we_i)
      check("read data", wb_dat_o, exp_q.pop_front());
  initial
  begin
    logic [4:0] en;
    logic [4:0] hit;
    logic [2:0] irq_exp;
    logic       act;
    int         done_n;
    int         t;
    void'($urandom(32'hb61c3b31));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, EIR_ADR_ENABLE, 0, 32'h0);
    wb(0, EIR_ADR_DETECT, 0, 32'h0);
    wb(0, EIR_ADR_ICTRL, 0, 32'h0);
    wb(1, 8'h14, 32'hffffffff, 0);
    wb(0, 8'h14, 0, 32'h0);
    $display("test reset and map done");
    for (int n = 0; n < 5; n++)
      for (int m = 0; m < 4; m++)
      begin
        act = (m == EIR_DET_HIGH || m == EIR_DET_RISE);
        hit = 5'h01 << n;
        en  = 5'($urandom);
        set_in(hit, ~act);
        repeat (4) @(posedge clk_i);
        wb(1, EIR_ADR_DETECT, 32'(m) << (2 * n), 0);
        wb(1, EIR_ADR_ENABLE, 32'(en), 0);
        wb(1, EIR_ADR_CAUSE, 32'h1f, 0);
        wb(0, EIR_ADR_CAUSE, 0, 32'h0);
        set_in(hit, act);
        repeat (4) @(posedge clk_i);
        wb(0, EIR_ADR_CAUSE, 0, 32'(hit));
        for (int v = 0; v < 3; v++)
          irq_exp[v] = |(hit & en & EIR_VEC_MASK[v]);
        wb(0, EIR_ADR_STATUS, 0, {21'h0, irq_exp, 3'h0, act ? 5'h1f : ~hit});
        wb(1, EIR_ADR_CAUSE, 32'(hit), 0);
        wb(0, EIR_ADR_CAUSE, 0, m < 2 ? 32'(hit) : 32'h0);
      end
    $display("test detection done");
    delay <= 4'($urandom_range(3));
    set_in(5'h01, 1'b0);
    wb(1, EIR_ADR_DETECT, 32'h1, 0);
    wb(1, EIR_ADR_ENABLE, 32'h1, 0);
    wb(1, EIR_ADR_CAUSE, 32'h1f, 0);
    wb(1, EIR_ADR_ICTRL, 32'h0000_0201, 0);
    set_in(5'h01, 1'b1);
    done_n = 0;
    for (t = 0; t < 200 && irq_o[0] !== 1'b1; t++)
    begin
      @(posedge clk_i);
      done_n += int'(xfer_done_i[0]);
    end
    if (t == 200)
      hang("irq wait");
    check("transfers", done_n, 2);
    check("xfer req", xfer_req_o, 3'h0);
    wb(0, EIR_ADR_ICTRL, 0, 32'h1);
    wb(0, EIR_ADR_STATUS, 0, {21'h0, 3'h1, 3'h0, 5'h1f});
    $display("test transfer done");
    end_of_test();
  end
endmodule
